// file: bench/peirq_regs_tb.sv
// Self-checking bench for the PLL event interrupt register block.
// Assumes the design files are compiled first; the bench alone drives
// every input of the block on one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "peirq_consts.svh"

module peirq_regs_tb;
  import peirq_pkg::*;

  // ****************************************************************
  // Signals and bench state
  // ****************************************************************
  logic        ref_clk_i;    // Bench clock, 25 ns period
  logic        rst_n_i;      // Synchronous reset, active low
  peirq_vec_t  src;          // Source levels, bit 7 down to bit 0
  peirq_addr_t addr_i;       // Register address
  peirq_vec_t  wdata_i;      // Write data
  logic        wr_i;         // Write strobe
  logic        rd_i;         // Read strobe
  peirq_vec_t  rdata_o;      // Read data from the block
  logic        irq_o;        // Interrupt level from the block
  int          miscompares;  // Mismatches seen
  int          checks_done;  // Comparisons made
  int          seed;         // Fixed seed keeps runs repeatable
  peirq_vec_t  m_mask;       // Expected mask register
  peirq_vec_t  m_pol;        // Expected polarity register
  peirq_vec_t  m_flag;       // Expected sticky flags
  logic [1:0]  m_ctl;        // Expected control bits

  // ****************************************************************
  // Block under test
  // ****************************************************************
  peirq_regs u_dut (
    .ref_clk_i                  (ref_clk_i),
    .rst_n_i                    (rst_n_i),
    .pll1_lock_lost_i           (src[7]),
    .pll1_signal_lost_i         (src[6]),
    .pll1_calibrating_i         (src[5]),
    .pll2_lock_lost_i           (src[4]),
    .pll2_signal_lost_i         (src[3]),
    .pll2_calibrating_i         (src[2]),
    .pll1_auto_switch_primary_i (src[1]),
    .pll2_auto_switch_primary_i (src[0]),
    .addr_i                     (addr_i),
    .wdata_i                    (wdata_i),
    .wr_i                       (wr_i),
    .rd_i                       (rd_i),
    .rdata_o                    (rdata_o),
    .irq_o                      (irq_o)
  );

  // Free-running clock
  initial ref_clk_i = 1'b0;
  always #12.5 ref_clk_i = ~ref_clk_i;

  // ****************************************************************
  // Expectation helpers
  // ****************************************************************
  // Bits whose level change matches the chosen edge direction
  function automatic peirq_vec_t edge_hits(input peirq_vec_t old_l,
                                           input peirq_vec_t new_l,
                                           input peirq_vec_t pol);
    return (pol & ~old_l & new_l) | (~pol & old_l & ~new_l);
  endfunction

  // Interrupt level from flags, mask and control
  function automatic logic irq_exp(input peirq_vec_t fl,
                                   input peirq_vec_t mk,
                                   input logic [1:0] ctl);
    peirq_vec_t unm;
    unm = ~mk;
    if (!ctl[`PEIRQ_CTL_EN_BIT]) return 1'b0;
    if (ctl[`PEIRQ_CTL_AND_BIT]) return (unm != 8'h00) && ((fl & unm) == unm);
    return |(fl & unm);
  endfunction

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  // Single compare point, counts and reports
  task automatic check(input string nm, input peirq_vec_t seen,
                       input peirq_vec_t exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write
  task automatic wr_reg(input peirq_addr_t a, input peirq_vec_t d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd_chk(input string nm, input peirq_addr_t a,
                        input peirq_vec_t exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    check(nm, rdata_o, exp);
  endtask

  // New source levels, then wait past sync, edge and irq stages
  task automatic drive_src(input peirq_vec_t nv);
    @(posedge ref_clk_i);
    if (m_ctl[`PEIRQ_CTL_EN_BIT]) m_flag = m_flag | edge_hits(src, nv, m_pol);
    src <= nv;
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask

  // Interrupt pin, settled two edges after the last write
  task automatic check_irq();
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("irq", {7'h00, irq_o},
          {7'h00, irq_exp(m_flag, m_mask, m_ctl)});
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Counts: checks_done %0d miscompares %0d", checks_done,
             miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Watchdog, well beyond the expected 10k cycles
  // ****************************************************************
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    miscompares++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    peirq_vec_t w;
    rst_n_i = 1'b0;
    src = 8'h00;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    miscompares = 0;
    checks_done = 0;
    seed = 72744;
    m_mask = 8'h00;
    m_pol = 8'h00;
    m_flag = 8'h00;
    m_ctl = 2'h0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Reset values, an unmapped read and a write to the live register
    rd_chk("mask", `PEIRQ_OFS_MASK, 8'h00);
    rd_chk("pol", `PEIRQ_OFS_POL, 8'h00);
    rd_chk("flag", `PEIRQ_OFS_FLAG, 8'h00);
    rd_chk("ctl", `PEIRQ_OFS_CTL, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr_reg(`PEIRQ_OFS_LIVE, 8'hFF);
    rd_chk("live", `PEIRQ_OFS_LIVE, 8'h00);
    $display("Test reset values done");
    // Random configuration, source edges and clearing writes
    for (int i = 0; i < 300; i++) begin
      m_mask = 8'($random(seed));
      m_pol = 8'($random(seed));
      m_ctl = 2'($random(seed));
      wr_reg(`PEIRQ_OFS_MASK, m_mask);
      wr_reg(`PEIRQ_OFS_POL, m_pol);
      wr_reg(`PEIRQ_OFS_CTL, {6'h00, m_ctl});
      check_irq();
      rd_chk("mask", `PEIRQ_OFS_MASK, m_mask);
      rd_chk("pol", `PEIRQ_OFS_POL, m_pol);
      drive_src(8'($random(seed)));
      rd_chk("live", `PEIRQ_OFS_LIVE, src);
      rd_chk("flag", `PEIRQ_OFS_FLAG, m_flag);
      check_irq();
      w = 8'($random(seed));
      wr_reg(`PEIRQ_OFS_FLAG, w);
      m_flag = m_flag & w;
      rd_chk("flag", `PEIRQ_OFS_FLAG, m_flag);
      check_irq();
    end
    $display("Test random traffic done");
    // Corner: a clearing write meets a new edge in the same cycle
    m_pol  = 8'hFF;
    m_mask = 8'h00;
    m_ctl  = 2'h1;
    wr_reg(`PEIRQ_OFS_POL, m_pol);
    wr_reg(`PEIRQ_OFS_MASK, m_mask);
    wr_reg(`PEIRQ_OFS_CTL, {6'h00, m_ctl});
    drive_src(8'h00);
    wr_reg(`PEIRQ_OFS_FLAG, 8'h00);
    m_flag = 8'h00;
    @(posedge ref_clk_i);
    src <= 8'h81;
    // Two sync stages and the level stage bring the edge to the flags
    repeat (2) @(posedge ref_clk_i);
    wr_reg(`PEIRQ_OFS_FLAG, 8'h00);
    m_flag = 8'h81;
    rd_chk("flag", `PEIRQ_OFS_FLAG, m_flag);
    check_irq();
    $display("Test set beats clear done");
    // AND mode with every source masked never interrupts
    m_mask = 8'hFF;
    m_ctl = 2'h3;
    wr_reg(`PEIRQ_OFS_MASK, m_mask);
    wr_reg(`PEIRQ_OFS_CTL, {6'h00, m_ctl});
    check_irq();
    $display("Test all masked done");
    wrap_up();
  end

endmodule
`default_nettype wire

// file: design/peirq_consts.svh
// Constants for the PLL event interrupt register block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PEIRQ_CONSTS_SVH
`define PEIRQ_CONSTS_SVH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define PEIRQ_OFS_LIVE     8'h0D
`define PEIRQ_OFS_MASK     8'h0E
`define PEIRQ_OFS_POL      8'h0F
`define PEIRQ_OFS_FLAG     8'h10
`define PEIRQ_OFS_CTL      8'h11

// ****************************************************************
// Source bit positions, shared by all four source registers
// ****************************************************************
`define PEIRQ_BIT_PLL1_LOCK_LOST    7
`define PEIRQ_BIT_PLL1_SIGNAL_LOST  6
`define PEIRQ_BIT_PLL1_CALIBRATING  5
`define PEIRQ_BIT_PLL2_LOCK_LOST    4
`define PEIRQ_BIT_PLL2_SIGNAL_LOST  3
`define PEIRQ_BIT_PLL2_CALIBRATING  2
`define PEIRQ_BIT_PLL1_SWITCH       1
`define PEIRQ_BIT_PLL2_SWITCH       0

// ****************************************************************
// Control register fields
// ****************************************************************
`define PEIRQ_CTL_EN_BIT   0
`define PEIRQ_CTL_AND_BIT  1

// ****************************************************************
// Reset values
// ****************************************************************
`define PEIRQ_RST_MASK     8'h00
`define PEIRQ_RST_POL      8'h00
`define PEIRQ_RST_FLAG     8'h00
`define PEIRQ_RST_LEVEL    8'h00
`define PEIRQ_RST_CTL      2'h0
`define PEIRQ_RST_RDATA    8'h00

`endif

// file: design/peirq_pkg.sv
// Types and the address decoder of the PLL event interrupt block.
// Assumes the constants header sits beside it on the include path.
`include "peirq_consts.svh"

package peirq_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  // One bit per interrupt source, bit 7 down to bit 0
  typedef logic [7:0] peirq_vec_t;
  // Register address on the plain port
  typedef logic [7:0] peirq_addr_t;

  // Register selected by an address
  typedef enum {
    PEIRQ_SEL_LIVE,
    PEIRQ_SEL_MASK,
    PEIRQ_SEL_POL,
    PEIRQ_SEL_FLAG,
    PEIRQ_SEL_CTL,
    PEIRQ_SEL_NONE
  } peirq_sel_t;

  // ****************************************************************
  // Address decode, shared by the read and the write path
  // ****************************************************************
  function automatic peirq_sel_t peirq_decode(input peirq_addr_t addr);
    peirq_sel_t sel;
    case (addr)
      `PEIRQ_OFS_LIVE: sel = PEIRQ_SEL_LIVE;
      `PEIRQ_OFS_MASK: sel = PEIRQ_SEL_MASK;
      `PEIRQ_OFS_POL:  sel = PEIRQ_SEL_POL;
      `PEIRQ_OFS_FLAG: sel = PEIRQ_SEL_FLAG;
      `PEIRQ_OFS_CTL:  sel = PEIRQ_SEL_CTL;
      default:         sel = PEIRQ_SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

// file: design/peirq_regs.sv
// Interrupt status registers for a dual PLL clock generator.
// Assumes eight asynchronous source levels from the PLL logic and a
// software master on the plain register port, all on ref_clk_i.
//
// Summary of operation
// RULE1 - Live register always shows current source levels
// RULE2 - Bits 7..0: lock, signal, cal, switch
// RULE3 - Mask bit 1 stops source reaching interrupt
// RULE4 - Mask register same order, resets to zero
// RULE5 - Polarity 1: rising edge sets flag
// RULE6 - Polarity 0 (reset): falling edge sets flag
// RULE7 - Flags update only while enable is 1; flag writes still clear bits while it is 0
// RULE8 - Writing 0 clears the flag bit
// RULE9 - Flags same order, reset to zero
// RULE10 - No interrupt output while enable is 0
// RULE11 - Combine bit 1: AND, 0: OR
// RULE12 - Writing 1 keeps flag; set beats clear
// RULE13 - Edge: synced level against previous cycle
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "peirq_consts.svh"

module peirq_regs (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  // Interrupt sources, asynchronous levels
  input  wire logic                  pll1_lock_lost_i,
  input  wire logic                  pll1_signal_lost_i,
  input  wire logic                  pll1_calibrating_i,
  input  wire logic                  pll2_lock_lost_i,
  input  wire logic                  pll2_signal_lost_i,
  input  wire logic                  pll2_calibrating_i,
  input  wire logic                  pll1_auto_switch_primary_i,
  input  wire logic                  pll2_auto_switch_primary_i,
  // Register port
  input  wire peirq_pkg::peirq_addr_t addr_i,
  input  wire peirq_pkg::peirq_vec_t  wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output peirq_pkg::peirq_vec_t       rdata_o,
  // Interrupt request, level
  output logic                       irq_o
);

  import peirq_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  peirq_vec_t src_raw;        // Sources packed in register order
  peirq_vec_t src_sync;       // Sources after the synchroniser
  peirq_vec_t level_reg;      // Live levels, readable
  peirq_vec_t level_next;
  peirq_vec_t prev_reg;       // Levels one cycle earlier
  peirq_vec_t prev_next;
  peirq_vec_t rise_vec;       // Rising edges this cycle
  peirq_vec_t fall_vec;       // Falling edges this cycle
  peirq_vec_t set_vec;        // Flags to set this cycle
  peirq_vec_t mask_reg;       // Source mask, 1 blocks
  peirq_vec_t mask_next;
  peirq_vec_t pol_reg;        // Edge polarity, 1 rising
  peirq_vec_t pol_next;
  peirq_vec_t flags_reg;      // Sticky edge flags
  peirq_vec_t flags_next;
  logic [1:0] ctl_reg;        // Enable and combine mode
  logic [1:0] ctl_next;
  logic       en_w;           // Global interrupt enable
  logic       and_mode_w;     // Combine mode, 1 for AND
  peirq_vec_t rdata_reg;      // Read data, valid one cycle
  peirq_vec_t rdata_next;
  logic       irq_reg;        // Registered interrupt output
  logic       irq_next;
  peirq_vec_t active_w;       // Unmasked active flags
  peirq_sel_t wr_sel;         // Decoded write target
  peirq_sel_t rd_sel;         // Decoded read target

  // ****************************************************************
  // Source capture
  // ****************************************************************
  // Pack the pins into register bit order
  assign src_raw = {pll1_lock_lost_i,
                    pll1_signal_lost_i,
                    pll1_calibrating_i,
                    pll2_lock_lost_i,
                    pll2_signal_lost_i,
                    pll2_calibrating_i,
                    pll1_auto_switch_primary_i,
                    pll2_auto_switch_primary_i}; // RULE2

  // Pins are asynchronous, so two flops before any logic
  peirq_sync #(
    .WIDTH   ($bits(peirq_vec_t))
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (src_raw),
    .sync_o    (src_sync)
  );

  // Live and previous level, independent of the enable
  always_comb begin
    level_next = src_sync;  // RULE1
    prev_next  = level_reg; // RULE13
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      level_reg <= `PEIRQ_RST_LEVEL;
      prev_reg  <= `PEIRQ_RST_LEVEL;
    end else begin
      level_reg <= level_next;
      prev_reg  <= prev_next;
    end
  end

  // Edge detect on the registered level
  assign rise_vec = level_reg & ~prev_reg; // RULE13
  assign fall_vec = ~level_reg & prev_reg; // RULE13

  // Pick the edge each source asks for; only when enabled
  assign set_vec = en_w ? ((rise_vec & pol_reg) |
                           (fall_vec & ~pol_reg))
                        : '0; // RULE5 RULE6 RULE7

  // ****************************************************************
  // Software registers
  // ****************************************************************
  assign wr_sel     = peirq_decode(addr_i);
  assign rd_sel     = peirq_decode(addr_i);
  assign en_w       = ctl_reg[`PEIRQ_CTL_EN_BIT];
  assign and_mode_w = ctl_reg[`PEIRQ_CTL_AND_BIT];

  // Next values of mask, polarity, control and flags
  always_comb begin
    mask_next  = mask_reg;
    pol_next   = pol_reg;
    ctl_next   = ctl_reg;
    flags_next = flags_reg;
    if (wr_i) begin
      case (wr_sel)
        PEIRQ_SEL_MASK: begin
          mask_next = wdata_i; // RULE4
        end
        PEIRQ_SEL_POL: begin
          pol_next = wdata_i;
        end
        PEIRQ_SEL_CTL: begin
          ctl_next = {wdata_i[`PEIRQ_CTL_AND_BIT],
                      wdata_i[`PEIRQ_CTL_EN_BIT]};
        end
        PEIRQ_SEL_FLAG: begin
          // Zeros clear, ones leave the bit alone
          flags_next = flags_reg & wdata_i; // RULE8 RULE12
        end
        default: begin
          // Live register is read only; unmapped writes vanish
        end
      endcase
    end
    // Set after clear so a same-cycle edge is never lost
    flags_next = flags_next | set_vec; // RULE12
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mask_reg  <= `PEIRQ_RST_MASK;  // RULE4
      pol_reg   <= `PEIRQ_RST_POL;   // RULE6
      ctl_reg   <= `PEIRQ_RST_CTL;
      flags_reg <= `PEIRQ_RST_FLAG;  // RULE9
    end else begin
      mask_reg  <= mask_next;
      pol_reg   <= pol_next;
      ctl_reg   <= ctl_next;
      flags_reg <= flags_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Data is registered, so it stands only in the cycle after rd_i
  always_comb begin
    rdata_next = `PEIRQ_RST_RDATA;
    if (rd_i) begin
      case (rd_sel)
        PEIRQ_SEL_LIVE: rdata_next = level_reg; // RULE1
        PEIRQ_SEL_MASK: rdata_next = mask_reg;
        PEIRQ_SEL_POL:  rdata_next = pol_reg;
        PEIRQ_SEL_FLAG: rdata_next = flags_reg;
        PEIRQ_SEL_CTL: begin
          // Reserved control bits read as zero
          rdata_next = {6'h00, ctl_reg};
        end
        default: begin
          rdata_next = `PEIRQ_RST_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= `PEIRQ_RST_RDATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ****************************************************************
  // Interrupt combine
  // ****************************************************************
  assign active_w = flags_reg & ~mask_reg; // RULE3

  // AND needs every unmasked flag; with all masked nothing fires.
  // Output is a flop, so it trails the flags by one cycle.
  always_comb begin
    irq_next = 1'b0;
    if (en_w) begin
      if (and_mode_w) begin
        irq_next = (active_w == ~mask_reg) &&
                   (mask_reg != 8'hFF); // RULE11
      end else begin
        irq_next = (active_w != 8'h00); // RULE11
      end
    end // RULE10
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_LIVE_READ: assert property ( // RULE1
    (rd_i && addr_i == `PEIRQ_OFS_LIVE) |=> rdata_o == $past(src_sync, 2)
  ) else $error("live read does not show synced sources");

  AST_RISE_SET: assert property ( // RULE5
    (en_w && (rise_vec & pol_reg) != 8'h00) |=>
      (flags_reg & $past(rise_vec & pol_reg)) == $past(rise_vec & pol_reg)
  ) else $error("rising edge did not set its flag");

  AST_FALL_SET: assert property ( // RULE6
    (en_w && (fall_vec & ~pol_reg) != 8'h00) |=>
      (flags_reg & $past(fall_vec & ~pol_reg)) ==
      $past(fall_vec & ~pol_reg)
  ) else $error("falling edge did not set its flag");

  AST_NO_SET_DISABLED: assert property ( // RULE7
    !en_w |=> (flags_reg & ~$past(flags_reg)) == 8'h00
  ) else $error("flag set while interrupts disabled");

  AST_CLEAR_ZERO: assert property ( // RULE8
    (wr_i && addr_i == `PEIRQ_OFS_FLAG && set_vec == 8'h00) |=>
      flags_reg == ($past(flags_reg) & $past(wdata_i))
  ) else $error("flag write did not clear as written");

  AST_SET_WINS: assert property ( // RULE12
    (wr_i && addr_i == `PEIRQ_OFS_FLAG && set_vec != 8'h00) |=>
      (flags_reg & $past(set_vec)) == $past(set_vec)
  ) else $error("clearing write swallowed a new edge");

  AST_IRQ_OFF: assert property ( // RULE10
    !en_w |=> !irq_o
  ) else $error("interrupt raised while disabled");

  AST_OR_FIRES: assert property ( // RULE11
    (en_w && !and_mode_w && active_w != 8'h00) |=> irq_o
  ) else $error("OR mode missed an unmasked flag");

  AST_AND_NEEDS_ALL: assert property ( // RULE11
    (en_w && and_mode_w && active_w != ~mask_reg) |=> !irq_o
  ) else $error("AND mode fired without all flags");

  AST_MASK_BLOCKS: assert property ( // RULE3
    (!and_mode_w && active_w == 8'h00) |=> !irq_o
  ) else $error("masked flags raised the interrupt");

  AST_MASK_READ: assert property ( // RULE4
    (rd_i && addr_i == `PEIRQ_OFS_MASK) |=> rdata_o == $past(mask_reg)
  ) else $error("mask read back wrong");

  COV_RISE: cover property (en_w && (rise_vec & pol_reg) != 8'h00);
  COV_CLEAR: cover property (
    wr_i && addr_i == `PEIRQ_OFS_FLAG && flags_reg != 8'h00);
  COV_AND_IRQ: cover property (and_mode_w && irq_o);
  COV_DISABLED_EDGE: cover property (!en_w && fall_vec != 8'h00);

endmodule

`default_nettype wire

// file: design/peirq_sync.sv
// Two-stage level synchroniser, one lane per bit.
// Assumes inputs are asynchronous levels; pulses narrower than a
// clock period may be missed.
`timescale 1ns/1ps
`default_nettype none

module peirq_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  logic [WIDTH-1:0] meta_reg;   // First stage, read only by sync_reg
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;   // Second stage, safe to use
  logic [WIDTH-1:0] sync_next;

  // Next values: shift one stage per edge
  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  // Stage registers, synchronous reset to low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule

`default_nettype wire
